// >>> inc/ivt_params.svh
/*
 * constants of the interrupt vector and trap logic: counts, widths,
 * trap numbers, reset values and field positions.
 * assumes it is included once by the package ivt_pkg.
 */
`ifndef IVT_PARAMS_SVH
`define IVT_PARAMS_SVH

// ********************************************************************
// sizes
// ********************************************************************
`define IVT_NUM_SRC        56
`define IVT_LVL_W          4
`define IVT_VEC_W          24
`define IVT_TNUM_W         8
`define IVT_NUM_XP         4
`define IVT_XSEL_W         16
`define IVT_TCR_W          16

// ********************************************************************
// trap numbers and levels
// ********************************************************************
`define IVT_SRC_TNUM_BASE  8'h10
`define IVT_XP_BASE_IDX    48
`define IVT_TNUM_NMI       8'h02
`define IVT_TNUM_STK_OVER  8'h04
`define IVT_TNUM_STK_UNDER 8'h06
`define IVT_TNUM_CLASS_B   8'h0a
`define IVT_LVL_TOP        4'hf
`define IVT_LVL_RESET      4'hf

// ********************************************************************
// selection register fields and reset values
// ********************************************************************
`define IVT_XSEL_EN_LSB    8
`define IVT_XSEL_FLAG_LSB  0
`define IVT_XSEL_RESET     16'h0000
`define IVT_TCR_RESET      16'h0000

`endif

// >>> inc/ivt_pkg.sv
/*
 * types of the interrupt vector and trap logic.
 * assumes ivt_params.svh is on the include path.
 */
`include "ivt_params.svh"

package ivt_pkg;

	// ****************************************************************
	// per-source control word
	// ****************************************************************
	typedef struct packed {
		logic                  req;
		logic                  en;
		logic [`IVT_LVL_W-1:0] lvl;
	} ivt_ctrl_t;

	// ****************************************************************
	// hardware trap conditions, also the low bits of the cause register
	// ****************************************************************
	typedef struct packed {
		logic ill_bus;
		logic ill_instr;
		logic ill_operand;
		logic prot_fault;
		logic mac_intr;
		logic undef_opcode;
		logic stack_under;
		logic stack_over;
		logic nmi;
	} ivt_trap_t;

	// ****************************************************************
	// vector offered to the cpu core
	// ****************************************************************
	typedef struct packed {
		logic                   valid;
		logic                   is_trap;
		logic [5:0]             src;
		logic [`IVT_TNUM_W-1:0] trap_num;
		logic [`IVT_VEC_W-1:0]  vector;
	} ivt_offer_t;

	typedef enum logic [1:0] {
		SVC_NONE = 2'b00,
		SVC_B    = 2'b01,
		SVC_A    = 2'b10
	} ivt_svc_t;

endpackage

// >>> core/ivt_xsel.sv
/*
 * one shared extension-peripheral selection register: enable byte high,
 * event flag byte low, and the combined request line.
 * assumes events come from logic on core_clk.
 */
`timescale 1ns/1ps

module ivt_xsel
	import ivt_pkg::*;
(
	input  wire logic                   core_clk,
	input  wire logic                   reset_n,
	input  wire logic                   we,
	input  wire logic [`IVT_XSEL_W-1:0] wdata,
	input  wire logic [7:0]             src_event,
	output logic      [`IVT_XSEL_W-1:0] value,
	output logic                        line
);

	logic [`IVT_XSEL_W-1:0] sel_q;
	logic [`IVT_XSEL_W-1:0] sel_d;

	always_comb begin
		sel_d = sel_q;
		if (we) begin
			sel_d = wdata;
		end
		// set wins over a clearing write
		sel_d[`IVT_XSEL_FLAG_LSB +: 8] = sel_d[`IVT_XSEL_FLAG_LSB +: 8]
			| src_event; // [RQ8]
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			sel_q <= `IVT_XSEL_RESET;
		end else begin
			sel_q <= sel_d;
		end
	end

	assign value = sel_q;
	// masked flags still show in value for polling
	assign line  = |(sel_q[`IVT_XSEL_EN_LSB +: 8]
		& sel_q[`IVT_XSEL_FLAG_LSB +: 8]); // [RQ8]

endmodule

// >>> core/ivt_core.sv
/*
 * interrupt vector and trap dispatch: per-source request, enable and
 * level, four shared selection registers, hardware traps with a cause
 * register, and the vector offer to the cpu core.
 * assumes all inputs are on core_clk; the cpu acks the registered offer
 * and reports trap end and level restores.
 * source index i has trap number 10h+i, ordered by trap number.
 */
`timescale 1ns/1ps

// Behaviour
// RQ1: every source has own request flag, enable flag, vector and trap number.
// RQ2: vector address equals trap number times four.
// RQ3: run-time error takes an unmaskable hardware trap to its own vector; code sends all six class B traps to the one vector of trap number 0Ah.
// RQ4: each hardware trap sets its own bit in the trap cause register.
// RQ5: trap preempts all but a higher priority trap service in progress; code blocks all traps in class A service, class B in class B.
// RQ6: during trap service, interrupts and transfer requests are blocked.
// RQ7: each source has a four-bit level; only strictly higher levels preempt.
// RQ8: selection register: enables high byte, flags low byte, ored to vector.
// RQ9: reset and hardware trap service force the cpu level to fifteen.
module ivt_core
	import ivt_pkg::*;
#(
	parameter int NSRC = `IVT_NUM_SRC
)(
	input  wire logic                                core_clk,
	input  wire logic                                reset_n,
	input  wire logic [NSRC-1:0]                     src_event,
	input  wire logic [`IVT_NUM_XP*8-1:0]            xp_event,
	input  wire logic [`IVT_NUM_XP-1:0]              xsel_we,
	input  wire logic [`IVT_XSEL_W-1:0]              xsel_wdata,
	output logic      [`IVT_NUM_XP*`IVT_XSEL_W-1:0]  xsel_value,
	input  wire logic                                cfg_we,
	input  wire logic [5:0]                          cfg_idx,
	input  wire ivt_ctrl_t                           cfg_wdata,
	input  wire logic [5:0]                          cfg_rd_idx,
	output ivt_ctrl_t                                cfg_rd_data,
	input  wire ivt_trap_t                           trap_event,
	input  wire logic                                tcr_clr_we,
	input  wire logic [`IVT_TCR_W-1:0]               tcr_clr_mask,
	output logic      [`IVT_TCR_W-1:0]               trap_cause_register,
	output ivt_offer_t                               offer,
	input  wire logic                                cpu_ack,
	input  wire logic                                trap_done,
	input  wire logic                                level_we,
	input  wire logic [`IVT_LVL_W-1:0]               level_wdata,
	output logic      [`IVT_LVL_W-1:0]               cpu_priority_level,
	output logic                                     trap_in_service,
	output logic                                     pec_allow
);

	// ****************************************************************
	// helpers
	// ****************************************************************
	function automatic logic [`IVT_VEC_W-1:0] vec_of(
		input logic [`IVT_TNUM_W-1:0] tnum
	);
		vec_of = {{(`IVT_VEC_W-`IVT_TNUM_W-2){1'b0}}, tnum, 2'b00}; // [RQ2]
	endfunction

	function automatic ivt_offer_t make_offer(
		input logic                   is_trap,
		input logic [5:0]             src,
		input logic [`IVT_TNUM_W-1:0] tnum
	);
		make_offer.valid    = 1'b1;
		make_offer.is_trap  = is_trap;
		make_offer.src      = src;
		make_offer.trap_num = tnum;
		make_offer.vector   = vec_of(tnum);
	endfunction

	// ****************************************************************
	// shared extension-peripheral selection registers
	// ****************************************************************
	logic [`IVT_NUM_XP-1:0] xp_line;
	logic [`IVT_NUM_XP-1:0] xp_line_q;

	genvar gx;
	generate
		for (gx = 0; gx < `IVT_NUM_XP; gx++) begin : g_xsel
			ivt_xsel u_xsel (
				.core_clk  (core_clk),
				.reset_n   (reset_n),
				.we        (xsel_we[gx]),
				.wdata     (xsel_wdata),
				.src_event (xp_event[gx*8 +: 8]),
				.value     (xsel_value[gx*`IVT_XSEL_W +: `IVT_XSEL_W]),
				.line      (xp_line[gx])
			);
		end
	endgenerate

	// ****************************************************************
	// state
	// ****************************************************************
	logic [NSRC-1:0]            req_q, req_d, en_q, en_d;
	logic [`IVT_LVL_W-1:0]      lvl_q [NSRC];
	logic [`IVT_LVL_W-1:0]      lvl_d [NSRC];
	logic [NSRC-1:0]            set_req;
	logic [8:0]                 tpend_q, tpend_d;
	logic [`IVT_TCR_W-1:0]      tcr_q, tcr_d;
	ivt_svc_t                   svc_q, svc_d;
	logic                       b_under_q, b_under_d;
	logic [`IVT_LVL_W-1:0]      level_q, level_d;
	ivt_offer_t                 offer_q, offer_d;
	ivt_ctrl_t                  rd_q, rd_d;
	logic                       take;
	logic                       found;
	logic [5:0]                 best_idx;
	logic [`IVT_LVL_W-1:0]      best_lvl;
	logic                       pend_a, pend_b;
	logic [`IVT_TNUM_W-1:0]     a_tnum;

	assign take = offer_q.valid && cpu_ack;

	// ****************************************************************
	// arbitration
	// ****************************************************************
	always_comb begin
		found    = 1'b0;
		best_idx = 6'h00;
		best_lvl = '0;
		// ties go to the lower index, which is the lower trap number
		for (int i = 0; i < NSRC; i++) begin
			if (req_q[i] && en_q[i] && (!found || lvl_q[i] > best_lvl)) begin
				found    = 1'b1;
				best_idx = 6'(i);
				best_lvl = lvl_q[i];
			end
		end
		pend_a = |tpend_q[2:0];
		pend_b = |tpend_q[8:3];
		if (tpend_q[0]) begin
			a_tnum = `IVT_TNUM_NMI;
		end else if (tpend_q[1]) begin
			a_tnum = `IVT_TNUM_STK_OVER;
		end else begin
			a_tnum = `IVT_TNUM_STK_UNDER;
		end
	end

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		req_d     = req_q;
		en_d      = en_q;
		lvl_d     = lvl_q;
		tpend_d   = tpend_q;
		svc_d     = svc_q;
		b_under_d = b_under_q;
		level_d   = level_q;
		offer_d   = '0;
		tcr_d     = tcr_q;
		rd_d.req  = req_q[cfg_rd_idx];
		rd_d.en   = en_q[cfg_rd_idx];
		rd_d.lvl  = lvl_q[cfg_rd_idx];

		if (cfg_we) begin
			req_d[cfg_idx] = cfg_wdata.req; // [RQ1]
			en_d[cfg_idx]  = cfg_wdata.en; // [RQ1]
			lvl_d[cfg_idx] = cfg_wdata.lvl; // [RQ7]
		end
		if (level_we) begin
			level_d = level_wdata;
		end
		if (trap_done) begin
			svc_d     = (svc_q == SVC_A && b_under_q) ? SVC_B : SVC_NONE;
			b_under_d = 1'b0;
		end

		if (take) begin
			if (offer_q.is_trap) begin
				level_d = `IVT_LVL_TOP; // [RQ9]
				case (offer_q.trap_num)
					`IVT_TNUM_NMI:       tpend_d[0] = 1'b0;
					`IVT_TNUM_STK_OVER:  tpend_d[1] = 1'b0;
					`IVT_TNUM_STK_UNDER: tpend_d[2] = 1'b0;
					default:             tpend_d[8:3] = 6'h00;
				endcase
				if (offer_q.trap_num == `IVT_TNUM_CLASS_B) begin
					svc_d = SVC_B;
				end else begin
					b_under_d = (svc_q == SVC_B);
					svc_d     = SVC_A;
				end
			end else begin
				req_d[offer_q.src] = 1'b0;
				level_d = lvl_q[offer_q.src]; // [RQ7]
			end
		end

		// events win over any clear in the same cycle
		req_d   = req_d | set_req; // [RQ1]
		tpend_d = tpend_d | trap_event; // [RQ3]
		if (tcr_clr_we) begin
			tcr_d = tcr_q & ~tcr_clr_mask;
		end
		tcr_d[8:0] = tcr_d[8:0] | trap_event; // [RQ4]

		// a stale offer is withdrawn for a cycle after it is taken
		if (!take) begin
			if (pend_a && svc_q != SVC_A) begin
				offer_d = make_offer(1'b1, 6'h00, a_tnum); // [RQ3] [RQ5]
			end else if (pend_b && svc_q == SVC_NONE) begin
				offer_d = make_offer(1'b1, 6'h00, `IVT_TNUM_CLASS_B); // [RQ5]
			end else if (found && best_lvl > level_q
				&& svc_q == SVC_NONE) begin // [RQ6] [RQ7]
				offer_d = make_offer(1'b0, best_idx,
					`IVT_SRC_TNUM_BASE + {2'b00, best_idx}); // [RQ1]
			end
		end
	end

	// shared vectors raise their request on a rising combined line
	always_comb begin
		set_req = src_event;
		for (int x = 0; x < `IVT_NUM_XP; x++) begin
			set_req[`IVT_XP_BASE_IDX + x] = src_event[`IVT_XP_BASE_IDX + x]
				| (xp_line[x] & ~xp_line_q[x]); // [RQ8]
		end
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			req_q     <= '0;
			en_q      <= '0;
			lvl_q     <= '{default: '0};
			tpend_q   <= '0;
			tcr_q     <= `IVT_TCR_RESET;
			svc_q     <= SVC_NONE;
			b_under_q <= 1'b0;
			level_q   <= `IVT_LVL_RESET; // [RQ9]
			offer_q   <= '0;
			rd_q      <= '0;
			xp_line_q <= '0;
		end else begin
			req_q     <= req_d;
			en_q      <= en_d;
			lvl_q     <= lvl_d;
			tpend_q   <= tpend_d;
			tcr_q     <= tcr_d;
			svc_q     <= svc_d;
			b_under_q <= b_under_d;
			level_q   <= level_d;
			offer_q   <= offer_d;
			rd_q      <= rd_d;
			xp_line_q <= xp_line;
		end
	end

	assign cfg_rd_data         = rd_q;
	assign trap_cause_register = tcr_q;
	assign offer               = offer_q;
	assign cpu_priority_level  = level_q;
	assign trap_in_service     = (svc_q != SVC_NONE);
	assign pec_allow           = (svc_q == SVC_NONE); // [RQ6]

endmodule

// >>> test/ivt_cpu_model.sv
/* cpu core stand-in: takes each offered vector after ack_dly cycles.
   assumes offer is registered on core_clk. */
`timescale 1ns/1ps
module ivt_cpu_model
	import ivt_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       reset_n,
	input  wire ivt_offer_t offer,
	input  wire logic [1:0] ack_dly,
	output logic            cpu_ack
);
// ********
// accept
// ********
	// ack is a one-cycle pulse, dropped the cycle after it rises or as soon as the offer goes away
	int cnt;
	always @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			cpu_ack <= 1'b0;
			cnt     <= 0;
		end else if (!offer.valid || cpu_ack) begin
			cpu_ack <= 1'b0;
			cnt     <= 0;
		end else if (cnt >= int'(ack_dly)) begin
			cpu_ack <= 1'b1;
		end else begin
			cnt <= cnt + 1;
		end
	end
endmodule

// >>> test/ivt_core_chk.sv
/* assertions on the dispatch ports of ivt_core.
   assumes one clock domain and the bind at the foot. */
`timescale 1ns/1ps
module ivt_core_chk
	import ivt_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire ivt_offer_t  offer,
	input wire logic        cpu_ack,
	input wire ivt_trap_t   trap_event,
	input wire logic [15:0] trap_cause_register,
	input wire logic [3:0]  cpu_priority_level,
	input wire logic        trap_in_service,
	input wire logic        pec_allow
);
// ********
// checks
// ********
	default clocking dc @(posedge core_clk);
	endclocking
	default disable iff (!reset_n);
	AST_VEC_X4: assert property (
		offer.valid |-> offer.vector == {14'h0, offer.trap_num, 2'b00})
		else $error("vector not trap number times four");
	AST_IRQ_TNUM: assert property (
		offer.valid && !offer.is_trap |->
		offer.trap_num == 8'h10 + {2'b00, offer.src})
		else $error("source trap number wrong");
	AST_TCR_SET: assert property (
		|trap_event |=> (trap_cause_register[8:0] & $past(trap_event))
		== $past(trap_event))
		else $error("cause bit not set");
	AST_NMI_OFFER: assert property (
		trap_event.nmi && !trap_in_service && !(offer.valid && cpu_ack)
		##1 !(offer.valid && cpu_ack)
		|=> offer.valid && offer.is_trap && offer.trap_num == 8'h02)
		else $error("nmi not offered");
	AST_TRAP_TAKE: assert property (
		offer.valid && offer.is_trap && cpu_ack
		|=> cpu_priority_level == 4'hf && trap_in_service)
		else $error("trap take without level 15");
	AST_PEC_BLOCK: assert property (
		pec_allow == !trap_in_service)
		else $error("transfer channel not blocked");
	AST_IRQ_BLOCK: assert property (
		trap_in_service && offer.valid |-> offer.is_trap)
		else $error("interrupt offered in trap service");
	AST_IRQ_LVL: assert property (
		offer.valid && !offer.is_trap && cpu_ack
		|=> cpu_priority_level > $past(cpu_priority_level))
		else $error("interrupt not of higher level");
	cover property (offer.valid && offer.is_trap && cpu_ack);
	cover property (offer.valid && !offer.is_trap && cpu_ack);
	cover property (trap_in_service && offer.valid && cpu_ack);
endmodule
bind ivt_core ivt_core_chk i_chk (.core_clk(core_clk), .reset_n(reset_n),
	.offer(offer), .cpu_ack(cpu_ack), .trap_event(trap_event),
	.trap_cause_register(trap_cause_register),
	.cpu_priority_level(cpu_priority_level),
	.trap_in_service(trap_in_service), .pec_allow(pec_allow));

// >>> test/ivt_core_tb.sv
/* self-checking bench of ivt_core against a level model.
   assumes the cpu stand-in acks offers. */
`timescale 1ns/1ps
module ivt_core_tb
	import ivt_pkg::*;
;
// ********
// bench
// ********
	logic core_clk = 0, reset_n = 0, cfg_we = 0, tcr_clr_we = 0;
	logic trap_done = 0, level_we = 0, cpu_ack;
	logic [55:0] src_event = '0;
	logic [31:0] xp_event = '0, rng = 32'h3f;
	logic [3:0] xsel_we = '0, level_wdata = '0, cpu_priority_level;
	logic [15:0] xsel_wdata = '0, tcr_clr_mask = '0, trap_cause_register;
	logic [63:0] xsel_value;
	logic [5:0] cfg_idx = '0, cfg_rd_idx = '0;
	logic [1:0] ack_dly = '0;
	logic trap_in_service, pec_allow;
	ivt_ctrl_t cfg_wdata = '0, cfg_rd_data;
	ivt_trap_t trap_event = '0;
	ivt_offer_t offer, o;
	int error_cnt = 0, check_count = 0, cur, a, b, j;
	int req_m[56], en_m[56], lvl_m[56];
	always #5 core_clk = ~core_clk;
	ivt_core i_dut (.core_clk(core_clk), .reset_n(reset_n),
		.src_event(src_event), .xp_event(xp_event), .xsel_we(xsel_we),
		.xsel_wdata(xsel_wdata), .xsel_value(xsel_value),
		.cfg_we(cfg_we), .cfg_idx(cfg_idx), .cfg_wdata(cfg_wdata),
		.cfg_rd_idx(cfg_rd_idx), .cfg_rd_data(cfg_rd_data),
		.trap_event(trap_event),
		.tcr_clr_we(tcr_clr_we), .tcr_clr_mask(tcr_clr_mask),
		.trap_cause_register(trap_cause_register), .offer(offer),
		.cpu_ack(cpu_ack), .trap_done(trap_done), .level_we(level_we),
		.level_wdata(level_wdata),
		.cpu_priority_level(cpu_priority_level),
		.trap_in_service(trap_in_service), .pec_allow(pec_allow));
	ivt_cpu_model i_cpu (.core_clk(core_clk), .reset_n(reset_n),
		.offer(offer), .ack_dly(ack_dly), .cpu_ack(cpu_ack));
	function automatic int rnd(int m);
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return int'(rng % m);
	endfunction
	// highest level strictly above cpu, ties to lowest index
	function automatic int pick();
		int e = -1;
		for (int i = 0; i < 56; i++)
			if (req_m[i] && en_m[i] && lvl_m[i] > cur &&
				(e < 0 || lvl_m[i] > lvl_m[e])) e = i;
		return e;
	endfunction
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic take();
		int n = 0;
		while (!(offer.valid === 1'b1 && cpu_ack === 1'b1) && n < 60) begin
			tick();
			n++;
		end
		o = offer;
		chk(n < 60, 1);
		tick();
	endtask
	task automatic cfg(input int i, input int l);
		cfg_we = 1;
		cfg_idx = 6'(i);
		cfg_rd_idx = 6'(i);
		cfg_wdata = '{1'b0, 1'b1, 4'(l)};
		en_m[i] = 1;
		lvl_m[i] = l;
		tick();
		cfg_we = 0;
		tick();
		chk(cfg_rd_data, {2'b01, 4'(l)});
	endtask
	task automatic setlvl(input int l);
		level_we = 1;
		level_wdata = 4'(l);
		cur = l;
		tick();
		level_we = 0;
	endtask
	task automatic take_irq();
		int e;
		take();
		e = pick();
		chk({o.is_trap, o.src}, e);
		chk(o.trap_num, 16 + e);
		chk(o.vector, (16 + e) * 4);
		chk(cpu_priority_level, lvl_m[e]);
		req_m[e] = 0;
		cur = lvl_m[e];
	endtask
	task automatic pulse_done();
		trap_done = 1;
		tcr_clr_we = 1;
		tcr_clr_mask = 16'hffff;
		tick();
		trap_done = 0;
		tcr_clr_we = 0;
		tick();
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#100000;
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (3) @(posedge core_clk);
		#1 reset_n = 1;
		chk({cpu_priority_level, pec_allow}, 5'h1f);
		for (int t = 0; t < 6; t++) begin
			a = t == 0 ? 32 : rnd(48);
			b = (a + 1 + rnd(46)) % 48;
			ack_dly = 2'(rnd(4));
			setlvl(0);
			cfg(a, 1 + rnd(15));
			cfg(b, t == 1 ? lvl_m[a] : 1 + rnd(15));
			src_event[a] = 1;
			src_event[b] = 1;
			req_m[a] = 1;
			req_m[b] = 1;
			tick();
			src_event = '0;
			take_irq();
			setlvl(0);
			take_irq();
		end
		setlvl(5);
		cfg(3, 5);
		src_event[3] = 1;
		req_m[3] = 1;
		tick();
		src_event = '0;
		repeat (4) tick();
		chk(offer.valid, 0);
		setlvl(4);
		take_irq();
		$display("interrupt tests done");
		for (int k = 0; k < 9; k++) begin
			trap_event = ivt_trap_t'(9'h1 << k);
			tick();
			trap_event = '0;
			chk(trap_cause_register, 16'h1 << k);
			take();
			chk(o.trap_num, k < 3 ? 2 + 2 * k : 10);
			chk(o.vector, (k < 3 ? 2 + 2 * k : 10) * 4);
			chk({cpu_priority_level, pec_allow}, 5'h1e);
			pulse_done();
			tick();
			chk({trap_in_service, pec_allow}, 1);
		end
		setlvl(0);
		cfg(7, 9);
		trap_event.nmi = 1;
		src_event[7] = 1;
		req_m[7] = 1;
		tick();
		src_event = '0;
		trap_event = 9'h008;
		take();
		trap_event = '0;
		chk(o.trap_num, 2);
		setlvl(0);
		repeat (4) tick();
		chk(offer.valid, 0);
		pulse_done();
		take();
		chk(o.trap_num, 8'h0a);
		trap_event.nmi = 1;
		tick();
		trap_event = '0;
		take();
		chk(o.trap_num, 2);
		pulse_done();
		pulse_done();
		setlvl(0);
		take_irq();
		$display("trap tests done");
		for (int x = 0; x < 4; x++) begin
			j = rnd(8);
			setlvl(0);
			cfg(48 + x, 1 + rnd(15));
			xp_event[8 * x + j] = 1;
			tick();
			xp_event = '0;
			repeat (3) tick();
			chk(offer.valid, 0);
			chk(xsel_value[16 * x +: 16], 16'h1 << j);
			xsel_we[x] = 1;
			xsel_wdata = 16'h101 << j;
			req_m[48 + x] = 1;
			tick();
			xsel_we = '0;
			take_irq();
			xsel_we[x] = 1;
			xsel_wdata = '0;
			tick();
			xsel_we = '0;
		end
		$display("selection tests done");
		summarize();
	end
endmodule
